//--- essr_map.vh
/*
 holds the constants of the fault and signal strength status registers:
 register addresses, command bytes and fault codes.
 assumes it is included by bare name into each design file that needs it.
*/
// Contract
// - an unexpected event stores its fault code in the register at 0x79
// - reading the fault register clears the pending fault and the notify line
// - a new fault overwrites an unread code; no queue of older codes
// - codes 0x08 serial overrun, 0x09 radio overrun, 0x13 write failure
// - codes 0x20 missing ack, 0x40 payload check, 0x42 header check
// - codes 0x43 wrong sequence number, 0x44 unsupported frame kind
// - last good strength at 0x7b loads only when payload goes out serially
// - each good packet overwrites last good strength; only latest kept
// - strength values are 8-bit two's complement dBm
// - read of 0x7c takes a fresh measurement before the answer
// - strength values are corrected for the selected amplifier gain
// - factory custom ident: high byte at 0x39, low byte at 0x3a
`ifndef ESSR_MAP_VH
`define ESSR_MAP_VH
// ==========================================================
// register addresses
`define ESSR_ADDR_IDENT_HI 8'h39
`define ESSR_ADDR_IDENT_LO 8'h3a
`define ESSR_ADDR_FAULT 8'h79
`define ESSR_ADDR_LAST_RSS 8'h7b
`define ESSR_ADDR_INST_RSS 8'h7c
// ==========================================================
// command framing bytes
`define ESSR_CMD_HEADER 8'hff
`define ESSR_CMD_SIZE 8'h02
`define ESSR_CMD_ESCAPE 8'hfe
`define ESSR_RSP_ACK 8'h06
// ==========================================================
// fault codes
`define ESSR_FC_NONE 8'h00
`define ESSR_FC_SER_OVR 8'h08
`define ESSR_FC_RAD_OVR 8'h09
`define ESSR_FC_WR_FAIL 8'h13
`define ESSR_FC_NO_ACK 8'h20
`define ESSR_FC_PAY_CHK 8'h40
`define ESSR_FC_HDR_CHK 8'h42
`define ESSR_FC_BAD_SEQ 8'h43
`define ESSR_FC_BAD_FRM 8'h44
// ==========================================================
// field sizes and counts
`define ESSR_NUM_FAULTS 8
`define ESSR_GAIN_W 2
`define ESSR_RSP_LAST 2'h2
// ==========================================================
// gain correction per amplifier setting, and the signed byte limits
`define ESSR_GAIN_OFS_AGC 8'h00
`define ESSR_GAIN_OFS_HS 8'h00
`define ESSR_GAIN_OFS_MID 8'h07
`define ESSR_GAIN_OFS_LIN 8'h0a
`define ESSR_DBM_MIN 8'h80
`define ESSR_DBM_MAX 8'h7f
// ==========================================================
// reset value of every stored byte
`define ESSR_REG_RST 8'h00
`endif

//--- essr_fault_encode.v
/*
 holds the fault event priority encoder: picks one code per cycle.
 assumes the event pulses are on sys_clk; lowest index has priority.
*/
`timescale 1ns/1ps
`include "essr_map.vh"
module essr_fault_encode (
    fault_events,
    any_fault,
    fault_code
);
    input wire [7:0] fault_events;
    output reg any_fault;
    output reg [7:0] fault_code;
    // ==========================================================
    // code lookup
    function [7:0] essr_code_of;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: essr_code_of = `ESSR_FC_SER_OVR;
                3'h1: essr_code_of = `ESSR_FC_RAD_OVR;
                3'h2: essr_code_of = `ESSR_FC_WR_FAIL;
                3'h3: essr_code_of = `ESSR_FC_NO_ACK;
                3'h4: essr_code_of = `ESSR_FC_PAY_CHK;
                3'h5: essr_code_of = `ESSR_FC_HDR_CHK;
                3'h6: essr_code_of = `ESSR_FC_BAD_SEQ;
                default: essr_code_of = `ESSR_FC_BAD_FRM;
            endcase
        end
    endfunction
    integer i;
    // scan from the top so the lowest index wins on coincident events
    always @* begin
        any_fault = 1'b0;
        fault_code = `ESSR_FC_NONE;
        for (i = `ESSR_NUM_FAULTS - 1; i >= 0; i = i - 1) begin
            if (fault_events[i]) begin
                any_fault = 1'b1;
                fault_code = essr_code_of(i[2:0]);
            end
        end
    end
endmodule // essr_fault_encode

//--- essr_gain_adjust.v
/*
 holds the gain correction of a raw strength sample into dBm.
 assumes raw_level is already a signed dBm figure at the antenna port
 as seen through the amplifier; offsets are per gain setting.
*/
`timescale 1ns/1ps
`include "essr_map.vh"
module essr_gain_adjust (
    raw_level,
    gain_sel,
    dbm_level
);
    input wire [7:0] raw_level;
    input wire [1:0] gain_sel;
    output reg [7:0] dbm_level;
    reg [8:0] sum;
    reg [7:0] offset;
    // add the per-gain correction, saturating so the signed byte never wraps
    always @* begin
        case (gain_sel)
            2'h0: offset = `ESSR_GAIN_OFS_AGC;
            2'h1: offset = `ESSR_GAIN_OFS_HS;
            2'h2: offset = `ESSR_GAIN_OFS_MID;
            default: offset = `ESSR_GAIN_OFS_LIN;
        endcase
        sum = {raw_level[7], raw_level} + {1'b0, offset};
        if (sum[8] != sum[7])
            dbm_level = sum[8] ? `ESSR_DBM_MIN : `ESSR_DBM_MAX;
        else
            dbm_level = sum[7:0];
    end
endmodule // essr_gain_adjust

//--- essr_status_regs.v
/*
 holds the fault and signal strength status registers with their serial
 byte command decoder and answer sequencer.
 assumes rx bytes arrive as one-cycle strobes from a uart on sys_clk, the
 tx side takes a byte on tx_valid and tx_ready, and the strength sampler
 answers a request within a bounded time with sample_valid.
*/
`timescale 1ns/1ps
`include "essr_map.vh"
module essr_status_regs (
    sys_clk,
    rst,
    rx_valid,
    rx_byte,
    tx_valid,
    tx_byte,
    tx_ready,
    fault_events,
    fault_notify_line,
    fault_notify_enable,
    good_packet_out,
    packet_level,
    sample_request,
    sample_valid,
    sample_level,
    gain_sel,
    custom_ident_high,
    custom_ident_low
);
    input wire sys_clk;
    input wire rst;
    input wire rx_valid;
    input wire [7:0] rx_byte;
    output wire tx_valid;
    output reg [7:0] tx_byte;
    input wire tx_ready;
    input wire [7:0] fault_events;
    output wire fault_notify_line;
    input wire fault_notify_enable;
    input wire good_packet_out;
    input wire [7:0] packet_level;
    output wire sample_request;
    input wire sample_valid;
    input wire [7:0] sample_level;
    input wire [1:0] gain_sel;
    input wire [7:0] custom_ident_high;
    input wire [7:0] custom_ident_low;

    // ==========================================================
    // states
    localparam [2:0] ST_HDR = 3'h0;
    localparam [2:0] ST_SIZE = 3'h1;
    localparam [2:0] ST_ESC = 3'h2;
    localparam [2:0] ST_ADDR = 3'h3;
    localparam [2:0] ST_MEAS = 3'h4;
    localparam [2:0] ST_RSP = 3'h5;

    reg [2:0] state_ff, nxt_state;
    reg [7:0] addr_ff, nxt_addr;
    reg [1:0] rsp_idx_ff, nxt_rsp_idx;
    reg [7:0] value_ff, nxt_value;
    reg [7:0] fault_ff, nxt_fault;
    reg pending_ff, nxt_pending;
    reg [7:0] last_rss_ff, nxt_last_rss;
    reg [7:0] inst_rss_ff, nxt_inst_rss;
    reg [7:0] tx_byte_q;

    wire any_fault;
    wire [7:0] new_code;
    wire [7:0] pkt_dbm;
    wire [7:0] inst_dbm;

    // ==========================================================
    // helpers
    essr_fault_encode u_enc (
        .fault_events(fault_events),
        .any_fault(any_fault),
        .fault_code(new_code)
    );

    essr_gain_adjust u_gain_pkt (
        .raw_level(packet_level),
        .gain_sel(gain_sel),
        .dbm_level(pkt_dbm)
    );

    essr_gain_adjust u_gain_inst (
        .raw_level(sample_level),
        .gain_sel(gain_sel),
        .dbm_level(inst_dbm)
    );

    // ==========================================================
    // register read mux
    function [8:0] essr_read;
        input [7:0] a;
        input [7:0] ih;
        input [7:0] il;
        input [7:0] fc;
        input [7:0] lr;
        input [7:0] ir;
        begin
            case (a)
                `ESSR_ADDR_IDENT_HI: essr_read = {1'b1, ih};
                `ESSR_ADDR_IDENT_LO: essr_read = {1'b1, il};
                `ESSR_ADDR_FAULT: essr_read = {1'b1, fc};
                `ESSR_ADDR_LAST_RSS: essr_read = {1'b1, lr};
                `ESSR_ADDR_INST_RSS: essr_read = {1'b1, ir};
                default: essr_read = {1'b0, 8'h00};
            endcase
        end
    endfunction

    wire [8:0] rd_hit;
    assign rd_hit = essr_read(rx_byte, custom_ident_high, custom_ident_low,
        fault_ff, last_rss_ff, inst_rss_ff);

    wire tx_take;
    assign tx_valid = (state_ff == ST_RSP);
    assign tx_take = tx_valid && tx_ready;
    assign sample_request = (state_ff == ST_MEAS);
    assign fault_notify_line = pending_ff && fault_notify_enable;

    // ==========================================================
    // command decode and answer
    always @* begin
        nxt_state = state_ff;
        nxt_addr = addr_ff;
        nxt_rsp_idx = rsp_idx_ff;
        nxt_value = value_ff;
        nxt_inst_rss = inst_rss_ff;
        case (state_ff)
            ST_HDR: begin
                if (rx_valid && rx_byte == `ESSR_CMD_HEADER)
                    nxt_state = ST_SIZE;
            end
            ST_SIZE: begin
                if (rx_valid)
                    nxt_state = (rx_byte == `ESSR_CMD_SIZE) ? ST_ESC : ST_HDR;
            end
            ST_ESC: begin
                // writes are handled elsewhere; only the read form is ours
                if (rx_valid)
                    nxt_state = (rx_byte == `ESSR_CMD_ESCAPE) ?
                        ST_ADDR : ST_HDR;
            end
            ST_ADDR: begin
                if (rx_valid) begin
                    nxt_addr = rx_byte;
                    nxt_value = rd_hit[7:0];
                    nxt_rsp_idx = 2'h0;
                    if (!rd_hit[8])
                        nxt_state = ST_HDR;
                    else if (rx_byte == `ESSR_ADDR_INST_RSS)
                        nxt_state = ST_MEAS;
                    else
                        nxt_state = ST_RSP;
                end
            end
            ST_MEAS: begin
                if (sample_valid) begin
                    nxt_inst_rss = inst_dbm;
                    nxt_value = inst_dbm;
                    nxt_state = ST_RSP;
                end
            end
            ST_RSP: begin
                if (tx_take) begin
                    nxt_rsp_idx = rsp_idx_ff + 2'h1;
                    if (rsp_idx_ff == `ESSR_RSP_LAST)
                        nxt_state = ST_HDR;
                end
            end
            default: nxt_state = ST_HDR;
        endcase
    end

    always @* begin
        case (rsp_idx_ff)
            2'h0: tx_byte_q = `ESSR_RSP_ACK;
            2'h1: tx_byte_q = addr_ff;
            default: tx_byte_q = value_ff;
        endcase
        tx_byte = tx_byte_q;
    end

    // ==========================================================
    // fault register
    // the fault value is latched at address time, so clear on that byte
    wire fault_read;
    assign fault_read = (state_ff == ST_ADDR) && rx_valid &&
        (rx_byte == `ESSR_ADDR_FAULT);

    always @* begin
        nxt_fault = fault_ff;
        nxt_pending = pending_ff;
        if (fault_read) begin
            nxt_fault = `ESSR_FC_NONE;
            nxt_pending = 1'b0;
        end
        // a new event wins over the clear and replaces any unread code
        if (any_fault) begin
            nxt_fault = new_code;
            nxt_pending = 1'b1;
        end
    end

    // ==========================================================
    // last good packet strength
    always @* begin
        nxt_last_rss = last_rss_ff;
        if (good_packet_out)
            nxt_last_rss = pkt_dbm;
    end

    // ==========================================================
    // state
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_HDR;
            addr_ff <= `ESSR_REG_RST;
            rsp_idx_ff <= 2'h0;
            value_ff <= `ESSR_REG_RST;
            fault_ff <= `ESSR_FC_NONE;
            pending_ff <= 1'b0;
            last_rss_ff <= `ESSR_REG_RST;
            inst_rss_ff <= `ESSR_REG_RST;
        end else begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
            rsp_idx_ff <= nxt_rsp_idx;
            value_ff <= nxt_value;
            fault_ff <= nxt_fault;
            pending_ff <= nxt_pending;
            last_rss_ff <= nxt_last_rss;
            inst_rss_ff <= nxt_inst_rss;
        end
    end
endmodule // essr_status_regs

//--- essr_status_regs_properties.sv
/*
 assertion checker for the fault and strength status registers.
 assumes it is bound onto essr_status_regs; one clock, async reset rst.
*/
`timescale 1ns/1ps
module essr_props (
    input wire sys_clk,
    input wire rst,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    input wire tx_valid,
    input wire [7:0] tx_byte,
    input wire tx_ready,
    input wire [7:0] fault_events,
    input wire fault_notify_line,
    input wire fault_notify_enable,
    input wire sample_request,
    input wire sample_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // sequences
    // the host sends whole commands only while the block is idle
    sequence rd_fault_s;
        rx_valid && rx_byte == 8'hff ##1 rx_valid && rx_byte == 8'h02
        ##1 rx_valid && rx_byte == 8'hfe ##1 rx_valid && rx_byte == 8'h79;
    endsequence
    sequence rd_inst_s;
        rx_valid && rx_byte == 8'hff ##1 rx_valid && rx_byte == 8'h02
        ##1 rx_valid && rx_byte == 8'hfe ##1 rx_valid && rx_byte == 8'h7c;
    endsequence
    sequence ans_start_s;
        $rose(tx_valid) && tx_byte == 8'h06;
    endsequence
    sequence ans_flow_s;
        (tx_valid && tx_ready) [*3];
    endsequence
    // ==========================================================
    // properties
    fault_sets_line_a: assert property (
        fault_events != 8'h00 ##1 fault_notify_enable |-> fault_notify_line)
        else $error("notify line not raised after fault");
    read_clears_a: assert property (
        rd_fault_s ##0 fault_events == 8'h00 |=> !fault_notify_line)
        else $error("notify line not cleared by read");
    line_needs_en_a: assert property (
        fault_notify_line |-> fault_notify_enable)
        else $error("notify line high while unused");
    ack_first_a: assert property (
        $rose(tx_valid) |-> tx_byte == 8'h06)
        else $error("answer does not open with ack");
    byte_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("answer byte not held");
    answer_len_a: assert property (
        ans_start_s ##0 ans_flow_s |=> !tx_valid)
        else $error("answer longer than three bytes");
    meas_first_a: assert property (
        rd_inst_s |=> sample_request && !tx_valid)
        else $error("answer before fresh measurement");
    meas_answer_a: assert property (
        sample_request && sample_valid |=> tx_valid && tx_byte == 8'h06)
        else $error("no answer after measurement");
    meas_hold_a: assert property (
        sample_request && !sample_valid |=> sample_request)
        else $error("measurement request dropped early");
endmodule // essr_props
bind essr_status_regs essr_props u_essr_props (.sys_clk(sys_clk), .rst(rst),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .fault_events(fault_events),
    .fault_notify_line(fault_notify_line),
    .fault_notify_enable(fault_notify_enable),
    .sample_request(sample_request), .sample_valid(sample_valid));

//--- essr_host.sv
/*
 host model: sends read commands and takes the three answer bytes.
 assumes it shares sys_clk with the register block.
*/
`timescale 1ns/1ps
module essr_host (
    input wire sys_clk,
    output reg rx_valid,
    output reg [7:0] rx_byte,
    input wire tx_valid,
    input wire [7:0] tx_byte,
    output reg tx_ready
);
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
    end
    // ==========================================================
    // read command; the wait is bounded so an unmapped address cannot hang
    task read_reg(input [7:0] adr, input integer stall, output [23:0] rsp,
        output integer got);
        integer i;
        begin
            got = 0;
            rsp = 24'h00_0000;
            for (i = 0; i < 4; i = i + 1) begin
                @(posedge sys_clk);
                rx_valid <= 1'b1;
                rx_byte <= i == 0 ? 8'hff : i == 1 ? 8'h02 :
                    i == 2 ? 8'hfe : adr;
            end
            @(posedge sys_clk);
            rx_valid <= 1'b0;
            rx_byte <= ~adr; // released line shows no stale byte
            for (i = 0; i < 40 && got < 3; i = i + 1) begin
                tx_ready <= i >= stall;
                @(posedge sys_clk);
                if (tx_valid === 1'b1 && tx_ready) begin
                    rsp = {rsp[15:0], tx_byte};
                    got = got + 1;
                end
            end
            tx_ready <= 1'b0;
            #1;
        end
    endtask
endmodule // essr_host

//--- test_essr_status_regs.sv
/*
 self-checking bench for the status register block.
 assumes the checker and host model files are compiled first.
*/
`timescale 1ns/1ps
module test_essr_status_regs;
    reg sys_clk;
    reg rst;
    wire rx_valid, tx_valid, tx_ready, fault_notify_line, sample_request;
    wire [7:0] rx_byte, tx_byte;
    reg [7:0] fault_events, packet_level, sample_level, sample_meas;
    reg fault_notify_enable, good_packet_out, sample_valid;
    reg [1:0] gain_sel;
    reg [2:0] wait_cnt;
    reg [23:0] rsp;
    reg [63:0] code_tab;
    integer got, n_errors, samples_checked, cycles, i;
    essr_status_regs u_essr_status_regs (.sys_clk(sys_clk), .rst(rst),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready), .fault_events(fault_events),
        .fault_notify_line(fault_notify_line),
        .fault_notify_enable(fault_notify_enable),
        .good_packet_out(good_packet_out), .packet_level(packet_level),
        .sample_request(sample_request), .sample_valid(sample_valid),
        .sample_level(sample_level), .gain_sel(gain_sel),
        .custom_ident_high(8'ha5), .custom_ident_low(8'h3c));
    essr_host u_essr_host (.sys_clk(sys_clk), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready));
    // ==========================================================
    // helpers
    function [7:0] adj(input [7:0] lvl, input [1:0] g);
        integer v;
        begin
            v = $signed(lvl) + (g == 2'h2 ? 7 : g == 2'h3 ? 10 : 0);
            adj = v > 127 ? 8'h7f : v < -128 ? 8'h80 : v[7:0];
        end
    endfunction
    task check(input [31:0] seen, input [31:0] expct);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== expct) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: %h expected %h", $time, seen,
                    expct);
            end
        end
    endtask
    task summarize;
        begin
            $display("%0d errors in %0d checks", n_errors, samples_checked);
            if (n_errors == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task pulse_fault(input integer b);
        begin
            @(posedge sys_clk);
            fault_events <= 8'h01 << b;
            @(posedge sys_clk);
            fault_events <= 8'h00;
            #1;
        end
    endtask
    // ==========================================================
    // scenarios
    task t_codes;
        for (i = 0; i < 8; i = i + 1) begin
            pulse_fault(i);
            check(fault_notify_line, 1'b1);
            u_essr_host.read_reg(8'h79, 0, rsp, got);
            check(rsp, {16'h0679, code_tab[i*8 +: 8]});
            check(fault_notify_line, 1'b0);
        end
    endtask
    task t_overwrite;
        begin
            @(posedge sys_clk);
            fault_notify_enable <= 1'b0;
            pulse_fault(0);
            check(fault_notify_line, 1'b0);
            fault_notify_enable <= 1'b1;
            pulse_fault(7);
            u_essr_host.read_reg(8'h79, 2, rsp, got);
            check(rsp, 24'h06_7944);
            u_essr_host.read_reg(8'h79, 0, rsp, got);
            check(rsp, 24'h06_7900);
        end
    endtask
    task t_ident_unmapped;
        begin
            u_essr_host.read_reg(8'h39, 3, rsp, got);
            check(rsp, 24'h06_39a5);
            u_essr_host.read_reg(8'h3a, 0, rsp, got);
            check(rsp, 24'h06_3a3c);
            u_essr_host.read_reg(8'h7a, 0, rsp, got);
            check(got, 0);
        end
    endtask
    task t_last;
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge sys_clk);
            gain_sel <= i[1:0];
            packet_level <= 8'hc4 + i[7:0];
            good_packet_out <= 1'b1;
            @(posedge sys_clk);
            good_packet_out <= 1'b0;
            packet_level <= 8'h7c; // no strobe, so this must not load
            u_essr_host.read_reg(8'h7b, 0, rsp, got);
            check(rsp, {16'h067b, adj(8'hc4 + i[7:0], i[1:0])});
        end
    endtask
    task t_instant;
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge sys_clk);
            gain_sel <= 2'h2 + i[1:0];
            sample_meas <= i == 0 ? 8'hb0 : 8'h7c;
            u_essr_host.read_reg(8'h7c, 1, rsp, got);
            check(rsp, {16'h067c, i == 0 ? 8'hb7 : 8'h7f});
        end
    endtask
    task t_reset;
        begin
            pulse_fault(1);
            check(fault_notify_line, 1'b1);
            @(posedge sys_clk);
            rst <= 1'b1;
            repeat (3) @(posedge sys_clk);
            rst <= 1'b0;
            #1;
            check(fault_notify_line, 1'b0);
            u_essr_host.read_reg(8'h79, 0, rsp, got);
            check(rsp, 24'h06_7900);
            u_essr_host.read_reg(8'h7b, 0, rsp, got);
            check(rsp, 24'h06_7b00);
        end
    endtask
    // ==========================================================
    // sampler stand-in: slow answer, level is junk outside the strobe
    always @(posedge sys_clk) begin
        if (rst) begin
            wait_cnt <= 3'h0;
            sample_valid <= 1'b0;
            sample_level <= 8'h00;
        end else begin
            wait_cnt <= sample_request ? wait_cnt + 3'h1 : 3'h0;
            sample_valid <= sample_request && wait_cnt == 3'h3;
            sample_level <= sample_request && wait_cnt == 3'h3 ?
                sample_meas : ~sample_meas;
        end
    end
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            summarize;
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1;
        fault_events = 8'h00;
        packet_level = 8'h00;
        sample_meas = 8'h00;
        fault_notify_enable = 1'b1;
        good_packet_out = 1'b0;
        gain_sel = 2'h0;
        code_tab = 64'h4443_4240_2013_0908;
        n_errors = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_codes;
        t_overwrite;
        t_ident_unmapped;
        t_last;
        t_instant;
        t_reset;
        summarize;
    end
endmodule // test_essr_status_regs
